/* File: rtl/clic_defines.svh */
// constants for the cascaded legacy interrupt controller pair
`ifndef CLIC_DEFINES_SVH
`define CLIC_DEFINES_SVH
`define CLIC_M_EVEN     16'h0020
`define CLIC_M_ODD      16'h0021
`define CLIC_S_EVEN     16'h00A0
`define CLIC_S_ODD      16'h00A1
`define CLIC_LVL_LO     16'h04D0
`define CLIC_LVL_HI     16'h04D1
`define CLIC_LVL_RSVD   8'h05
`define CLIC_INIT_BIT   4
`define CLIC_SEL_HI     4
`define CLIC_SEL_LO     3
`define CLIC_SEL_OPERATION_WORD_TWO   2'h0
`define CLIC_SEL_OPERATION_WORD_THREE   2'h1
`define CLIC_CODE_HI    7
`define CLIC_CODE_LO    5
`define CLIC_EOI_NS     3'h1
`define CLIC_EOI_SP     3'h3
`define CLIC_EOI_RNS    3'h5
`define CLIC_EOI_RSP    3'h7
`define CLIC_LEVEL_HI   2
`define CLIC_VEC_HI     7
`define CLIC_VEC_LO     3
`define CLIC_POLL_BIT   2
`define CLIC_RR_BIT     1
`define CLIC_RIS_BIT    0
`define CLIC_CASC_LINE  3'h2
`define CLIC_SPURIOUS   3'h7
`define CLIC_BYTE_RST   8'h00
`define CLIC_REG_CMD    8'h00
`define CLIC_REG_STAT   8'h04
`define CLIC_REG_VBASE  8'h08
`define CLIC_CMD_WR     24
`define CLIC_CMD_RD     25
`define CLIC_CMD_INTA   26
`define CLIC_CMD_INIT   27
`define CLIC_INIT_WORD_ONE_VAL   8'h11
`define CLIC_MASTER_CASCADE_LINES_VAL  8'h04
`define CLIC_SLAVE_CASCADE_NUMBER_VAL  8'h02
`define CLIC_INIT_WORD_FOUR_VAL   8'h01
`define CLIC_VBASE_RST  16'h7008
`define CLIC_INIT_LAST  3'h7
`define CLIC_RESP_OKAY  2'h0
`define CLIC_RESP_ERR   2'h2
`endif

/* File: rtl/clic_pkg.sv */
// shared types of the interrupt controller pair
package clic_pkg;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_W2  = 2'b01,
      ST_W3  = 2'b10,
      ST_W4  = 2'b11
   } clic_step_t;
   typedef enum logic [1:0] {
      H_IDLE  = 2'b00,
      H_ISSUE = 2'b01,
      H_WAIT  = 2'b10
   } clic_host_t;
endpackage

/* File: rtl/clic_io_if.sv */
// io port and acknowledge link between host and controller pair
`timescale 1ns/1ps
`default_nettype none
interface clic_io_if;
   logic [15:0] ioAddr;   // io port address
   logic [7:0]  ioWdata;  // write byte
   logic        ioWr;     // write strobe
   logic        ioRd;     // read strobe
   logic        intaReq;  // interrupt acknowledge strobe
   logic        ioAck;    // answer strobe
   logic [7:0]  ioRdata;  // read byte or vector
   logic        intr;     // interrupt to processor
   modport dev  (input ioAddr, ioWdata, ioWr, ioRd, intaReq,
                 output ioAck, ioRdata, intr);
   modport host (output ioAddr, ioWdata, ioWr, ioRd, intaReq,
                 input ioAck, ioRdata, intr);
endinterface
`default_nettype wire

/* File: rtl/clic_req_sampler.sv */
// synchroniser and edge detector for request pins
`timescale 1ns/1ps
`default_nettype none
module clic_req_sampler #(
   parameter int W = 8
) (
   input  wire logic         clock,  // system clock
   input  wire logic         rst_b,  // sync reset, low
   input  wire logic [W-1:0] pin,    // raw request pins
   output logic      [W-1:0] rise,   // rising edge seen
   output logic      [W-1:0] low     // pin held low
);
   logic [W-1:0] sync1_q;
   logic [W-1:0] sync2_q;
   logic [W-1:0] prev_q;

   // two stages before any logic looks at a pin
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q  <= '0;
      end else begin
         sync1_q <= pin;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // registered so request data leave from flip-flops
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rise <= '0;
         low  <= '0;
      end else begin
         rise <= sync2_q & ~prev_q;
         low  <= ~sync2_q;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/clic_dev_end.sv */
// master and slave legacy interrupt controllers, io port end
//
// Functional notes
// - master on ports 20h/21h, lines 0-7
// - slave on ports A0h/A1h, lines 8-15
// - even write, bit 4 set: start init
// - bits 4:3 00 op word two, 01 three
// - software sends init words two-four in order
// - vector bits 7:3, spacing bit ignored
// - trigger bit ignored; level select decides
// - first word: cascade, fourth word needed
// - master cascade lines always 04h
// - slave cascade number always 02h
// - fourth word bits 7:5 zero
// - nested bit low, unbuffered mode
// - automatic end bit ignored, explicit end
// - processor mode bit ignored, x86 mode
// - per-controller mask; master line 2 masks slave
// - op word two: nonspecific/specific end
// - read select request/in-service, poll acknowledge
// - low select bit edge, high level-low
`timescale 1ns/1ps
`default_nettype none
`include "clic_defines.svh"
module clic_dev_end (
   input  wire logic        clock,   // system clock
   input  wire logic        rst_b,   // sync reset, low
   clic_io_if.dev           io,      // io port link
   input  wire logic [15:0] irqPin   // request pins
);
   clic_pkg::clic_step_t step_q [2];
   logic [7:0]  imr_q [2];
   logic [7:0]  isr_q [2];
   logic [7:0]  edg_q [2];
   logic [4:0]  base_q [2];
   logic [1:0]  readIs_q;
   logic [1:0]  poll_q;
   logic [15:0] lvlSel_q;
   logic [15:0] rise;
   logic [15:0] low;
   logic [7:0]  irr [2];
   logic [7:0]  pend [2];
   logic [2:0]  reqIdx [2];
   logic [2:0]  isIdx [2];
   logic [1:0]  reqHit;
   logic [1:0]  isHit;
   logic [1:0]  want;
   logic [1:0]  hitC;
   logic [1:0]  wrEven;
   logic [1:0]  wrOdd;
   logic [1:0]  rdEven;
   logic [1:0]  pollRd;
   logic [1:0]  ack;
   logic        casc;
   logic [7:0]  vector;
   logic [2:0]  code;

   // lowest set bit wins: line 0 is highest priority
   function automatic logic [3:0] first(input logic [7:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 3'(i)};
         end
      end
      return r;
   endfunction

   clic_req_sampler #(.W(16)) u_samp (
      .clock (clock),
      .rst_b (rst_b),
      .pin   (irqPin),
      .rise  (rise),
      .low   (low)
   );

   // port decode per controller
   always_comb begin
      hitC[0] = io.ioAddr[15:1] == `CLIC_M_EVEN >> 1;
      hitC[1] = io.ioAddr[15:1] == `CLIC_S_EVEN >> 1;
      for (int c = 0; c < 2; c++) begin
         wrEven[c] = io.ioWr & hitC[c] & ~io.ioAddr[0];
         wrOdd[c]  = io.ioWr & hitC[c] & io.ioAddr[0];
         rdEven[c] = io.ioRd & hitC[c] & ~io.ioAddr[0];
         pollRd[c] = rdEven[c] & poll_q[c];
      end
   end

   // request, pending and priority resolution
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         irr[c] = (lvlSel_q[c*8 +: 8] & low[c*8 +: 8])
                | (~lvlSel_q[c*8 +: 8] & edg_q[c]);
      end
      // slave output enters master line 2
      {reqHit[1], reqIdx[1]} = first(irr[1] & ~imr_q[1]);
      {isHit[1], isIdx[1]}   = first(isr_q[1]);
      want[1] = reqHit[1] & (~isHit[1] | (reqIdx[1] < isIdx[1]));
      irr[0][`CLIC_CASC_LINE] = want[1];
      for (int c = 0; c < 2; c++) begin
         pend[c] = irr[c] & ~imr_q[c];
      end
      {reqHit[0], reqIdx[0]} = first(pend[0]);
      {isHit[0], isIdx[0]}   = first(isr_q[0]);
      want[0] = reqHit[0] & (~isHit[0] | (reqIdx[0] < isIdx[0]));
      casc = want[0] & (reqIdx[0] == `CLIC_CASC_LINE);
      ack[0] = io.intaReq | pollRd[0];
      ack[1] = (io.intaReq & casc) | pollRd[1];
      // cascaded acknowledge takes the slave vector
      if (casc) begin
         vector = {base_q[1], reqIdx[1]};
      end else if (want[0]) begin
         vector = {base_q[0], reqIdx[0]};
      end else begin
         vector = {base_q[0], `CLIC_SPURIOUS};
      end
      code = io.ioWdata[`CLIC_CODE_HI:`CLIC_CODE_LO];
   end

   // init sequence, vector base, mask and read mode
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         for (int c = 0; c < 2; c++) begin
            step_q[c] <= clic_pkg::ST_RUN;
            imr_q[c]  <= `CLIC_BYTE_RST;
            base_q[c] <= '0;
         end
         readIs_q <= '0;
         poll_q   <= '0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (pollRd[c]) begin
               poll_q[c] <= 1'b0;
            end
            if (wrEven[c] && io.ioWdata[`CLIC_INIT_BIT]) begin
               // only bit 4 matters; 7:5, 3, 2 are dropped
               step_q[c]   <= clic_pkg::ST_W2;
               imr_q[c]    <= `CLIC_BYTE_RST;
               readIs_q[c] <= 1'b0;
               poll_q[c]   <= 1'b0;
            end else if (wrEven[c] && io.ioWdata[`CLIC_SEL_HI:
                         `CLIC_SEL_LO] == `CLIC_SEL_OPERATION_WORD_THREE) begin
               if (io.ioWdata[`CLIC_RR_BIT]) begin
                  readIs_q[c] <= io.ioWdata[`CLIC_RIS_BIT];
               end
               poll_q[c] <= io.ioWdata[`CLIC_POLL_BIT];
            end
            if (wrOdd[c]) begin
               unique case (step_q[c])
                  clic_pkg::ST_W2: begin
                     base_q[c] <= io.ioWdata[`CLIC_VEC_HI:`CLIC_VEC_LO];
                     step_q[c] <= clic_pkg::ST_W3;
                  end
                  // cascade wiring is fixed, so the word is dropped
                  clic_pkg::ST_W3: step_q[c] <= clic_pkg::ST_W4;
                  // end and processor mode bits have no effect
                  clic_pkg::ST_W4: begin
                     step_q[c] <= clic_pkg::ST_RUN;
                  end
                  clic_pkg::ST_RUN: imr_q[c] <= io.ioWdata;
               endcase
            end
         end
      end
   end

   // edge latches and in-service; a set beats a same-cycle clear
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         for (int c = 0; c < 2; c++) begin
            edg_q[c] <= `CLIC_BYTE_RST;
            isr_q[c] <= `CLIC_BYTE_RST;
         end
      end else begin
         for (int c = 0; c < 2; c++) begin
            logic [7:0] isClr;
            logic [7:0] isSet;
            isClr = '0;
            isSet = '0;
            if (ack[c] && want[c]) begin
               isSet[reqIdx[c]] = 1'b1;
            end
            if (wrEven[c] && !io.ioWdata[`CLIC_INIT_BIT] &&
                io.ioWdata[`CLIC_SEL_HI:`CLIC_SEL_LO] ==
                `CLIC_SEL_OPERATION_WORD_TWO) begin
               // rotation is not offered, so rotating ends act plain
               if ((code == `CLIC_EOI_NS || code == `CLIC_EOI_RNS)
                   && isHit[c]) begin
                  isClr[isIdx[c]] = 1'b1;
               end else if (code == `CLIC_EOI_SP ||
                            code == `CLIC_EOI_RSP) begin
                  isClr[io.ioWdata[`CLIC_LEVEL_HI:0]] = 1'b1;
               end
            end
            isr_q[c] <= (isr_q[c] & ~isClr) | isSet;
            edg_q[c] <= (edg_q[c] & ~isSet) | rise[c*8 +: 8];
         end
      end
   end

   // level select register, reserved lines stay edge
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         lvlSel_q <= '0;
      end else if (io.ioWr && io.ioAddr == `CLIC_LVL_LO) begin
         lvlSel_q[7:0] <= io.ioWdata & ~`CLIC_LVL_RSVD;
      end else if (io.ioWr && io.ioAddr == `CLIC_LVL_HI) begin
         lvlSel_q[15:8] <= io.ioWdata;
      end
   end

   // one-cycle answer with registered data
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         io.ioAck   <= 1'b0;
         io.ioRdata <= `CLIC_BYTE_RST;
         io.intr    <= 1'b0;
      end else begin
         io.ioAck <= io.ioWr | io.ioRd | io.intaReq;
         io.intr  <= want[0];
         if (io.intaReq) begin
            io.ioRdata <= vector;
         end else if (pollRd[0] || pollRd[1]) begin
            io.ioRdata <= pollRd[1] ? {want[1], 4'h0, reqIdx[1]}
                                    : {want[0], 4'h0, reqIdx[0]};
         end else if (rdEven[0] || rdEven[1]) begin
            io.ioRdata <= rdEven[1] ? (readIs_q[1] ? isr_q[1] : irr[1])
                                    : (readIs_q[0] ? isr_q[0] : irr[0]);
         end else if (io.ioRd && io.ioAddr == `CLIC_M_ODD) begin
            io.ioRdata <= imr_q[0];
         end else if (io.ioRd && io.ioAddr == `CLIC_S_ODD) begin
            io.ioRdata <= imr_q[1];
         end else if (io.ioRd && io.ioAddr == `CLIC_LVL_LO) begin
            io.ioRdata <= lvlSel_q[7:0];
         end else if (io.ioRd && io.ioAddr == `CLIC_LVL_HI) begin
            io.ioRdata <= lvlSel_q[15:8];
         end else if (io.ioRd) begin
            io.ioRdata <= `CLIC_BYTE_RST;
         end
      end
   end
endmodule
`default_nettype wire

/* File: rtl/clic_host_end.sv */
// processor-side end: axi4-lite command registers to io cycles
`timescale 1ns/1ps
`default_nettype none
`include "clic_defines.svh"
module clic_host_end (
   input  wire logic        clock,          // system clock
   input  wire logic        rst_b,          // sync reset, low
   clic_io_if.host          io,             // io port link
   input  wire logic [7:0]  s_axi_awaddr,   // write address
   input  wire logic        s_axi_awvalid,  // write address valid
   output logic             s_axi_awready,  // write address ready
   input  wire logic [31:0] s_axi_wdata,    // write data
   input  wire logic [3:0]  s_axi_wstrb,    // byte enables
   input  wire logic        s_axi_wvalid,   // write data valid
   output logic             s_axi_wready,   // write data ready
   output logic [1:0]       s_axi_bresp,    // write response
   output logic             s_axi_bvalid,   // write response valid
   input  wire logic        s_axi_bready,   // write response ready
   input  wire logic [7:0]  s_axi_araddr,   // read address
   input  wire logic        s_axi_arvalid,  // read address valid
   output logic             s_axi_arready,  // read address ready
   output logic [31:0]      s_axi_rdata,    // read data
   output logic [1:0]       s_axi_rresp,    // read response
   output logic             s_axi_rvalid,   // read response valid
   input  wire logic        s_axi_rready    // read response ready
);
   clic_pkg::clic_host_t st_q;
   logic [7:0]  awAddr_q;
   logic        awHave_q;
   logic [31:0] wData_q;
   logic [3:0]  wStrb_q;
   logic        wHave_q;
   logic [31:0] cmd_q;
   logic [15:0] vbase_q;
   logic [7:0]  rdata_q;
   logic        init_q;
   logic [2:0]  initStep_q;
   logic        doWrite;
   logic        start;
   logic [15:0] seqAddr;
   logic [7:0]  seqData;

   assign s_axi_awready = ~awHave_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~wHave_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign doWrite = awHave_q & wHave_q & ~s_axi_bvalid;
   // commands arriving while busy are dropped, not queued
   assign start = doWrite & (awAddr_q == `CLIC_REG_CMD)
                & (st_q == clic_pkg::H_IDLE);

   // canned init: first word, base, cascade, fourth, per side
   always_comb begin
      seqAddr = initStep_q[2] ? `CLIC_S_ODD : `CLIC_M_ODD;
      unique case (initStep_q[1:0])
         2'h0: begin
            seqAddr = initStep_q[2] ? `CLIC_S_EVEN : `CLIC_M_EVEN;
            seqData = `CLIC_INIT_WORD_ONE_VAL;
         end
         2'h1: seqData = initStep_q[2] ? vbase_q[15:8] : vbase_q[7:0];
         2'h2: seqData = initStep_q[2] ? `CLIC_SLAVE_CASCADE_NUMBER_VAL
                                       : `CLIC_MASTER_CASCADE_LINES_VAL;
         2'h3: seqData = `CLIC_INIT_WORD_FOUR_VAL;
      endcase
   end

   // address and data captured in either order
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         awHave_q     <= 1'b0;
         wHave_q      <= 1'b0;
         awAddr_q     <= '0;
         wData_q      <= '0;
         wStrb_q      <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CLIC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHave_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHave_q     <= 1'b0;
            wHave_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_q == `CLIC_REG_CMD ||
                             awAddr_q == `CLIC_REG_VBASE)
                            ? `CLIC_RESP_OKAY : `CLIC_RESP_ERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // vector base register, byte lanes 0 and 1
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         vbase_q <= `CLIC_VBASE_RST;
      end else if (doWrite && awAddr_q == `CLIC_REG_VBASE) begin
         if (wStrb_q[0]) begin
            vbase_q[7:0] <= wData_q[7:0];
         end
         if (wStrb_q[1]) begin
            vbase_q[15:8] <= wData_q[15:8];
         end
      end
   end

   // io cycle sequencer: one strobe, then wait for the answer
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         st_q       <= clic_pkg::H_IDLE;
         cmd_q      <= '0;
         init_q     <= 1'b0;
         initStep_q <= '0;
         rdata_q    <= `CLIC_BYTE_RST;
      end else begin
         unique case (st_q)
            clic_pkg::H_IDLE: begin
               if (start) begin
                  cmd_q      <= wData_q;
                  init_q     <= wData_q[`CLIC_CMD_INIT];
                  initStep_q <= '0;
                  st_q       <= clic_pkg::H_ISSUE;
               end
            end
            clic_pkg::H_ISSUE: st_q <= clic_pkg::H_WAIT;
            clic_pkg::H_WAIT: begin
               if (io.ioAck) begin
                  rdata_q <= io.ioRdata;
                  if (init_q && initStep_q != `CLIC_INIT_LAST) begin
                     initStep_q <= initStep_q + 3'h1;
                     st_q       <= clic_pkg::H_ISSUE;
                  end else begin
                     init_q <= 1'b0;
                     st_q   <= clic_pkg::H_IDLE;
                  end
               end
            end
            default: st_q <= clic_pkg::H_IDLE;
         endcase
      end
   end

   // strobes last the single issue cycle
   always_comb begin
      io.ioAddr  = init_q ? seqAddr : cmd_q[15:0];
      io.ioWdata = init_q ? seqData : cmd_q[23:16];
      io.ioWr    = (st_q == clic_pkg::H_ISSUE)
                 & (init_q | cmd_q[`CLIC_CMD_WR]);
      io.ioRd    = (st_q == clic_pkg::H_ISSUE) & ~init_q
                 & ~cmd_q[`CLIC_CMD_WR] & cmd_q[`CLIC_CMD_RD];
      io.intaReq = (st_q == clic_pkg::H_ISSUE) & ~init_q
                 & ~cmd_q[`CLIC_CMD_WR] & ~cmd_q[`CLIC_CMD_RD]
                 & cmd_q[`CLIC_CMD_INTA];
   end

   // status read: last byte, busy, interrupt line
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= `CLIC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `CLIC_RESP_OKAY;
         s_axi_rdata  <= '0;
         if (s_axi_araddr == `CLIC_REG_STAT) begin
            s_axi_rdata[9:0] <= {io.intr, st_q != clic_pkg::H_IDLE,
                                 rdata_q};
         end else if (s_axi_araddr == `CLIC_REG_VBASE) begin
            s_axi_rdata[15:0] <= vbase_q;
         end else if (s_axi_araddr != `CLIC_REG_CMD) begin
            s_axi_rresp <= `CLIC_RESP_ERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: tb/clic_monitor.sv */
// io link checker for the interrupt controller pair
`timescale 1ns/1ps
`default_nettype none
module clic_monitor (
   input wire logic        clock,   // system clock
   input wire logic        rst_b,   // sync reset, low
   input wire logic [15:0] ioAddr,  // port address
   input wire logic [7:0]  ioWdata, // write byte
   input wire logic        ioWr,    // write strobe
   input wire logic        ioRd,    // read strobe
   input wire logic        intaReq, // acknowledge strobe
   input wire logic        ioAck,   // answer strobe
   input wire logic [7:0]  ioRdata, // answer byte
   input wire logic        intr     // processor request
);
   logic [7:0] lvlLo_q;
   logic [7:0] lvlHi_q;
   logic       mapped;
   // shadow of level select; low byte bits 0 and 2 can never be set
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         lvlLo_q <= 8'h00;
         lvlHi_q <= 8'h00;
      end else if (ioWr) begin
         if (ioAddr == 16'h04D0) lvlLo_q <= ioWdata & 8'hFA;
         if (ioAddr == 16'h04D1) lvlHi_q <= ioWdata;
      end
   end
   // ports that may answer with a non-zero byte
   assign mapped = ioAddr inside {16'h0020, 16'h0021, 16'h00A0, 16'h00A1,
                                  16'h04D0, 16'h04D1};
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   sequence sStb; ioWr || ioRd || intaReq; endsequence
   sequence sAns; ioAck; endsequence
   ack_follow_a: assert property (sStb |=> sAns)
      else $error("strobe left unanswered");
   ack_cause_a: assert property (
      sAns |-> $past(ioWr || ioRd || intaReq))
      else $error("answer without strobe");
   ack_pulse_a: assert property (sAns |=> !ioAck)
      else $error("answer longer than one cycle");
   strobe_gap_a: assert property (
      sStb |=> !(ioWr || ioRd || intaReq))
      else $error("strobes back to back");
   write_keeps_a: assert property (
      ioAck && $past(ioWr) |-> $stable(ioRdata))
      else $error("write changed read byte");
   unmapped_zero_a: assert property (
      ioRd && !mapped |=> ioRdata == 8'h00)
      else $error("unmapped port read not zero");
   level_low_a: assert property (
      ioRd && ioAddr == 16'h04D0 |=> ioRdata == lvlLo_q)
      else $error("low level select readback");
   level_high_a: assert property (
      ioRd && ioAddr == 16'h04D1 |=> ioRdata == lvlHi_q)
      else $error("high level select readback");
endmodule
`default_nettype wire

/* File: tb/tb_cascaded_legacy_interrupt_ctrl.sv */
// self-checking bench for the cascaded interrupt controller pair
`timescale 1ns/1ps
`default_nettype none
module tb_cascaded_legacy_interrupt_ctrl;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic [15:0] irqPin = 16'h0000;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [31:0] s_axi_rdata, v;
   logic [15:0] seed = 16'h7516; // fixed start of the random stream
   logic [15:0] ev;
   logic [7:0]  r;
   int          n, fails = 0, check_count = 0;

   clic_io_if clic_io_if_i ();
   clic_dev_end clic_dev_end_i (.io(clic_io_if_i), .*);
   clic_host_end clic_host_end_i (.io(clic_io_if_i), .*);
   clic_monitor clic_monitor_i (.clock(clock), .rst_b(rst_b),
      .ioAddr(clic_io_if_i.ioAddr), .ioWdata(clic_io_if_i.ioWdata),
      .ioWr(clic_io_if_i.ioWr), .ioRd(clic_io_if_i.ioRd),
      .intaReq(clic_io_if_i.intaReq), .ioAck(clic_io_if_i.ioAck),
      .ioRdata(clic_io_if_i.ioRdata), .intr(clic_io_if_i.intr));

   // 4 ns clock
   always #2 clock = ~clock;

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // vector for a line with the canned bases 08h and 70h
   function automatic logic [7:0] vec(input int k);
      return (k < 8 ? 8'h08 : 8'h70) | 8'(k % 8);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // axi write: both channels offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      // ready stays up so a following call never drives it twice at once
   endtask
   // one io cycle through the command register, then wait for idle
   task automatic io(input logic [3:0] c, input logic [15:0] a,
                     input logic [7:0] d);
      wr(8'h00, {4'h0, c, d, a});
      do rd(8'h04); while (v[8] !== 1'b0);
      r = v[7:0];
   endtask
   // edge pulse long enough to pass the synchroniser
   task automatic pulse(input logic [15:0] m);
      irqPin <= m;
      repeat (6) @(posedge clock);
      irqPin <= 16'h0000;
      repeat (4) @(posedge clock);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // hang guard, far beyond the expected run
   initial begin
      repeat (30000) @(posedge clock);
      fails++;
      final_report();
   end

   initial begin
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      rd(8'h0C);
      chk(rs, 2'h2);
      wr(8'h0C, 32'h00000000);
      chk(rs, 2'h2);
      rd(8'h08);
      chk(v, 32'h00007008);
      io(4'h8, 16'h0000, 8'h00);
      seed = lfsr(seed);
      io(4'h1, 16'h04D0, seed[7:0]);
      io(4'h2, 16'h04D0, 8'h00);
      chk(r, seed[7:0] & 8'hFA);
      io(4'h1, 16'h04D1, seed[15:8]);
      io(4'h2, 16'h04D1, 8'h00);
      chk(r, seed[15:8]);
      io(4'h1, 16'h04D0, 8'h00);
      io(4'h1, 16'h04D1, 8'h00);
      // random single lines across both controllers
      repeat (8) begin
         seed = lfsr(seed);
         n = (seed[3:0] == 4'h2) ? 3 : int'(seed[3:0]);
         ev = (n < 8) ? 16'h0020 : 16'h00A0;
         pulse(16'h0001 << n);
         rd(8'h04);
         chk(v[9], 1'b1);
         io(4'h4, 16'h0000, 8'h00);
         chk(r, vec(n));
         io(4'h1, ev, 8'h0B);
         io(4'h2, ev, 8'h00);
         chk(r, 8'h01 << (n % 8));
         io(4'h1, ev, 8'h60 | 8'(n % 8));
         if (n >= 8) io(4'h1, 16'h0020, 8'h62);
         io(4'h2, ev, 8'h00);
         chk(r, 8'h00);
         io(4'h1, ev, 8'h0A);
      end
      // two lines together: the lower number wins
      pulse(16'h0028);
      io(4'h4, 16'h0000, 8'h00);
      chk(r, 8'h0B);
      io(4'h1, 16'h0020, 8'h20);
      io(4'h4, 16'h0000, 8'h00);
      chk(r, 8'h0D);
      // rotating non-specific end must act as a plain end
      io(4'h1, 16'h0020, 8'hA0);
      // masked line holds off until unmasked
      io(4'h1, 16'h0021, 8'hFF);
      pulse(16'h0010);
      rd(8'h04);
      chk(v[9], 1'b0);
      io(4'h1, 16'h0021, 8'h00);
      io(4'h4, 16'h0000, 8'h00);
      chk(r, 8'h0C);
      // rotating specific end for line 4; poll below needs it cleared
      io(4'h1, 16'h0020, 8'hE4);
      // masking the cascade line hides the slave
      io(4'h1, 16'h0021, 8'h04);
      pulse(16'h0200);
      rd(8'h04);
      chk(v[9], 1'b0);
      io(4'h1, 16'h0021, 8'h00);
      io(4'h4, 16'h0000, 8'h00);
      chk(r, 8'h71);
      io(4'h1, 16'h00A0, 8'h20);
      io(4'h1, 16'h0020, 8'h20);
      // poll read acts as the acknowledge
      pulse(16'h0040);
      io(4'h1, 16'h0020, 8'h0C);
      io(4'h2, 16'h0020, 8'h00);
      chk(r, 8'h86);
      io(4'h1, 16'h0020, 8'h20);
      // manual init with the ignored first-word, end and processor mode bits set
      io(4'h1, 16'h0020, 8'hFD);
      io(4'h1, 16'h0021, 8'h08);
      io(4'h1, 16'h0021, 8'h04);
      io(4'h1, 16'h0021, 8'h03);
      pulse(16'h0002);
      io(4'h4, 16'h0000, 8'h00);
      chk(r, 8'h09);
      io(4'h1, 16'h0020, 8'h0B);
      io(4'h2, 16'h0020, 8'h00);
      chk(r, 8'h02);
      // nothing pending: acknowledge answers with the spurious level
      io(4'h4, 16'h0000, 8'h00);
      chk(r, 8'h0F);
      final_report();
   end
endmodule
`default_nettype wire
